// *** hw/smr_pkg.sv ***
package smr_pkg;

	localparam int NUM_PORTS = 4;
	localparam int PW        = 2;
	localparam int BUS_W     = 8;
	localparam int DEV_W     = 5;
	localparam int SEQ_W     = 4;
	localparam int ADDR_W    = 8;
	localparam int DATA_W    = 32;
	localparam int VW_W      = 4;
	localparam int STICKY_W  = 4;

	localparam logic [PW-1:0]        PRIMARY_PORT    = 2'h0;
	localparam logic [NUM_PORTS-1:0] LOCAL_FUNC_MASK = 4'hf;

	// Register map: address bits [5:4] pick the port, bits [3:0] the register; bits [7:6] must be zero.
	localparam int          ADDR_PORT_LSB = 4;
	localparam int          ADDR_IDX_W    = 4;
	localparam logic [3:0]  REG_BUS       = 4'h0;
	localparam logic [3:0]  REG_CTRL      = 4'h1;
	localparam logic [3:0]  REG_STAT      = 4'h2;
	localparam logic [3:0]  REG_LINK1     = 4'h3;

	localparam int BUS_PRI_LSB = 0;
	localparam int BUS_SEC_LSB = 8;
	localparam int BUS_SUB_LSB = 16;
	localparam logic [DATA_W-1:0] BUS_RST = 32'h0000_0000;

	localparam int CTRL_DEFPORT_LSB  = 0;
	localparam int CTRL_UNIT_IDENTIFIER_LSB   = 8;
	localparam int CTRL_DEVNUM_LSB   = 16;
	localparam int CTRL_HIDE_BIT     = 21;
	localparam int CTRL_MAM_BIT      = 22;
	localparam int CTRL_SERR_BIT     = 23;
	localparam int CTRL_FLOOD_BIT    = 24;
	localparam int CTRL_FATAL_BIT    = 25;
	localparam int CTRL_NONFATAL_BIT = 26;
	localparam int CTRL_VT_BIT       = 27;
	localparam int CTRL_PMASK_LSB    = 28;
	localparam logic [DATA_W-1:0] CTRL_RST = 32'hf000_0000;

	localparam int STAT_VBUS_ABORT = 0;
	localparam int STAT_CHAIN_END  = 1;
	localparam int STAT_RMA        = 2;
	localparam int STAT_SSE        = 3;
	localparam int STAT_HOTSWAP    = 4;
	localparam int STAT_STOPPED    = 5;
	localparam int STAT_ACTIVE     = 6;
	localparam logic [STICKY_W-1:0] STAT_RST = 4'h0;

	typedef enum logic [2:0] {
		KIND_DEVMSG0,
		KIND_DEVMSG1,
		KIND_INTR,
		KIND_EOI,
		KIND_INTERRUPT_ACKNOWLEDGE,
		KIND_SYSMGMT
	} smr_kind_t;

	typedef enum logic [2:0] {
		ACT_NONE,
		ACT_LOCAL,
		ACT_FORWARD,
		ACT_REFLECT,
		ACT_DROP,
		ACT_REJECT,
		ACT_BROADCAST
	} smr_action_t;

endpackage

// *** hw/smr_switch_router.sv ***
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
module smr_switch_router (
	input  wire logic                                   clk_in,
	input  wire logic                                   sys_rst_in,
	input  wire logic [smr_pkg::ADDR_W-1:0]             reg_addr_in,
	input  wire logic [smr_pkg::DATA_W-1:0]             reg_wdata_in,
	input  wire logic                                   reg_wr_in,
	input  wire logic                                   reg_rd_in,
	output logic      [smr_pkg::DATA_W-1:0]             reg_rdata_out,
	input  wire logic                                   req_valid_in,
	input  wire logic [smr_pkg::PW-1:0]                 req_ingress_in,
	input  wire logic                                   req_upstream_in,
	input  wire smr_pkg::smr_kind_t                     req_kind_in,
	input  wire logic [smr_pkg::BUS_W-1:0]              req_bus_in,
	input  wire logic [smr_pkg::DEV_W-1:0]              req_dev_in,
	input  wire logic [smr_pkg::SEQ_W-1:0]              req_seq_in,
	input  wire logic [1:0]                             req_vw_line_in,
	input  wire logic                                   req_vw_assert_in,
	output logic                                        route_valid_out,
	output smr_pkg::smr_action_t                        route_action_out,
	output logic      [smr_pkg::PW-1:0]                 route_egress_out,
	output logic                                        route_type0_out,
	output logic                                        route_ordered_out,
	output logic                                        route_epoch_out,
	input  wire logic                                   resp_valid_in,
	input  wire logic [smr_pkg::PW-1:0]                 resp_dest_in,
	input  wire logic                                   resp_epoch_in,
	output logic                                        resp_forward_out,
	output logic                                        resp_discard_out,
	input  wire logic [smr_pkg::NUM_PORTS-1:0]          link_stop_n_in,
	input  wire logic [smr_pkg::NUM_PORTS-1:0]          hotplug_n_in,
	output logic      [smr_pkg::NUM_PORTS-1:0]          link_wake_request_n_out,
	output logic      [smr_pkg::NUM_PORTS-1:0]          port_cold_reset_out,
	output logic      [smr_pkg::NUM_PORTS-1:0]          port_tx_enable_out,
	output logic      [smr_pkg::NUM_PORTS-1:0]          port_link_init_out,
	output logic      [smr_pkg::NUM_PORTS-1:0]          term_nonposted_out,
	output logic      [smr_pkg::NUM_PORTS-1:0]          sync_flood_out,
	output logic                                        fatal_irq_out,
	output logic                                        nonfatal_irq_out,
	output logic      [smr_pkg::VW_W-1:0]               legacy_wire_interrupt_out
);
	import smr_pkg::*;

	logic [NUM_PORTS-1:0] stop_s1_reg;
	logic [NUM_PORTS-1:0] stop_n_reg;
	logic [NUM_PORTS-1:0] hp_s1_reg;
	logic [NUM_PORTS-1:0] hp_n_reg;

	logic [DATA_W-1:0]    bus_reg   [NUM_PORTS];
	logic [DATA_W-1:0]    bus_next  [NUM_PORTS];
	logic [DATA_W-1:0]    ctrl_reg  [NUM_PORTS];
	logic [DATA_W-1:0]    ctrl_next [NUM_PORTS];
	logic [STICKY_W-1:0]  stat_reg  [NUM_PORTS];
	logic [STICKY_W-1:0]  stat_next [NUM_PORTS];
	logic [VW_W-1:0]      vw_reg    [NUM_PORTS];
	logic [VW_W-1:0]      vw_next   [NUM_PORTS];
	logic [SEQ_W-1:0]     lseq_reg  [NUM_PORTS];
	logic [SEQ_W-1:0]     lseq_next [NUM_PORTS];
	logic [PW-1:0]        leg_reg   [NUM_PORTS];
	logic [PW-1:0]        leg_next  [NUM_PORTS];
	logic [NUM_PORTS-1:0] flood_reg,  flood_next;
	logic [NUM_PORTS-1:0] epoch_reg,  epoch_next;
	logic [NUM_PORTS-1:0] wake_reg,   wake_next;
	logic [NUM_PORTS-1:0] hp_prev_reg;
	logic [NUM_PORTS-1:0] inact_prev_reg;
	logic [DATA_W-1:0]    rdata_next;

	logic [BUS_W-1:0]     pri_bus [NUM_PORTS];
	logic [BUS_W-1:0]     sec_bus [NUM_PORTS];
	logic [BUS_W-1:0]     sub_bus [NUM_PORTS];
	logic [PW-1:0]        def_port[NUM_PORTS];
	logic [NUM_PORTS-1:0] pmask   [NUM_PORTS];
	logic [NUM_PORTS-1:0] in_range;
	logic [NUM_PORTS-1:0] vt_bound;
	logic [NUM_PORTS-1:0] hp_act;
	logic [NUM_PORTS-1:0] inactive;
	logic [NUM_PORTS-1:0] stopped;

	logic                 ra_valid;
	smr_action_t          ra_action;
	logic [PW-1:0]        ra_egress;
	logic                 ra_type0;
	logic                 ra_abort;
	logic                 ra_chain_err;
	logic [NUM_PORTS-1:0] hit;
	logic [PW:0]          hit_cnt;
	logic [PW-1:0]        hit_port;
	logic                 dev_ok;
	logic [PW-1:0]        dev_port;
	logic [PW-1:0]        ing;
	logic                 fatal_next;
	logic                 nonfatal_next;

	logic                 rv_reg;
	smr_action_t          ract_reg;
	logic [PW-1:0]        reg_eg_reg;
	logic                 rt0_reg;
	logic                 rord_reg;
	logic                 rep_reg;
	logic                 rord_next;

	logic                 rsel_ok;
	logic [PW-1:0]        rport;
	logic [3:0]           ridx;

	// Pins from outside the clock domain pass two flip-flops first.
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			stop_s1_reg <= '1;
			stop_n_reg  <= '1;
			hp_s1_reg   <= '1;
			hp_n_reg    <= '1;
		end else begin
			stop_s1_reg <= link_stop_n_in;
			stop_n_reg  <= stop_s1_reg;
			hp_s1_reg   <= hotplug_n_in;
			hp_n_reg    <= hp_s1_reg;
		end
	end

	assign ing      = req_ingress_in;
	assign dev_port = req_dev_in[PW-1:0];
	assign rport    = reg_addr_in[ADDR_PORT_LSB +: PW];
	assign ridx     = reg_addr_in[ADDR_IDX_W-1:0];
	assign rsel_ok  = (reg_addr_in[ADDR_W-1:ADDR_PORT_LSB+PW] == '0);

	always_comb begin
		for (int p = 0; p < NUM_PORTS; p++) begin
			pri_bus[p]  = bus_reg[p][BUS_PRI_LSB +: BUS_W];
			sec_bus[p]  = bus_reg[p][BUS_SEC_LSB +: BUS_W];
			sub_bus[p]  = bus_reg[p][BUS_SUB_LSB +: BUS_W];
			def_port[p] = ctrl_reg[p][CTRL_DEFPORT_LSB +: PW];
			pmask[p]    = ctrl_reg[p][CTRL_PMASK_LSB +: NUM_PORTS];
			in_range[p] = (req_bus_in >= sec_bus[p]) && (req_bus_in <= sub_bus[p]);
			vt_bound[p] = ctrl_reg[p][CTRL_VT_BIT] && (PW'(p) != PRIMARY_PORT);
			// A tunnel-bound port shares the primary's pins, so its own hot-plug pin is ignored.
			hp_act[p]   = !hp_n_reg[p] && (PW'(p) != PRIMARY_PORT) && !vt_bound[p];
			stopped[p]  = !stop_n_reg[p];
			inactive[p] = hp_act[p] || flood_reg[p];
		end
	end

	// Routing decision for the request standing at the input.
	always_comb begin
		hit      = '0;
		hit_cnt  = '0;
		hit_port = '0;
		for (int p = 0; p < NUM_PORTS; p++) begin
			if ((PW'(p) != ing) && (PW'(p) != PRIMARY_PORT) && pmask[ing][p] && in_range[p] && !vt_bound[p]) begin
				hit[p]   = 1'b1;
				hit_cnt  = hit_cnt + (PW+1)'(1);
				hit_port = PW'(p);
			end
		end
		dev_ok       = (req_dev_in < DEV_W'(NUM_PORTS)) && pmask[ing][dev_port];
		ra_valid     = req_valid_in;
		ra_action    = ACT_DROP;
		ra_egress    = ing;
		ra_type0     = 1'b0;
		ra_abort     = 1'b0;
		ra_chain_err = 1'b0;
		case (req_kind_in)
			KIND_DEVMSG0: begin
				if (!req_upstream_in && req_dev_in == ctrl_reg[ing][CTRL_UNIT_IDENTIFIER_LSB +: DEV_W]) begin
					ra_action = ACT_LOCAL;
				end else if (req_upstream_in && req_dev_in == ctrl_reg[ing][CTRL_DEVNUM_LSB +: DEV_W]
						&& !ctrl_reg[ing][CTRL_HIDE_BIT]) begin
					ra_action = ACT_LOCAL;
				end else begin
					ra_chain_err = 1'b1;
				end
			end
			KIND_DEVMSG1: begin
				if (!req_upstream_in) begin
					if (!in_range[ing]) begin
						ra_chain_err = 1'b1;
					end else if (req_bus_in == sec_bus[ing]) begin
						if (dev_ok) begin
							ra_action = ACT_LOCAL;
							ra_egress = dev_port;
						end else begin
							ra_abort = 1'b1;
						end
					end else if (hit_cnt != (PW+1)'(1)) begin
						ra_abort = 1'b1;
					end else begin
						ra_action = ACT_FORWARD;
						ra_egress = hit_port;
						ra_type0  = (req_bus_in == sec_bus[hit_port]);
					end
				end else begin
					if (req_bus_in == sec_bus[ing]) begin
						ra_action = ACT_REFLECT;
						ra_type0  = 1'b1;
					end else if (in_range[ing]) begin
						ra_action = ACT_REFLECT;
					end else if (req_bus_in == pri_bus[ing]) begin
						if (dev_ok) begin
							ra_action = ACT_LOCAL;
							ra_egress = dev_port;
						end else begin
							ra_abort = 1'b1;
						end
					end else if (!in_range[def_port[ing]]) begin
						ra_action = ACT_FORWARD;
						ra_egress = def_port[ing];
					end else if (hit_cnt != (PW+1)'(1)) begin
						ra_abort = 1'b1;
					end else begin
						ra_action = ACT_FORWARD;
						ra_egress = hit_port;
						ra_type0  = (req_bus_in == sec_bus[hit_port]);
					end
				end
			end
			KIND_INTR: begin
				if (req_upstream_in) begin
					ra_action = ACT_FORWARD;
					ra_egress = def_port[ing];
				end
			end
			KIND_EOI: begin
				ra_action = ACT_BROADCAST;
			end
			KIND_INTERRUPT_ACKNOWLEDGE: begin
				if (!req_upstream_in) begin
					ra_action = ACT_FORWARD;
					ra_egress = def_port[ing];
				end
			end
			KIND_SYSMGMT: begin
				if (req_upstream_in) begin
					ra_action = ACT_FORWARD;
					ra_egress = def_port[ing];
				end else begin
					ra_action = ACT_BROADCAST;
				end
			end
			default: begin
				ra_action = ACT_DROP;
			end
		endcase
		// A tunnel-bound port forwards only to its bound primary and takes forwards only from it.
		if (vt_bound[ing] && ra_action == ACT_FORWARD) begin
			ra_egress = def_port[ing];
		end
		if (ra_action == ACT_FORWARD && vt_bound[ra_egress] && ing != def_port[ra_egress]) begin
			ra_action = ACT_DROP;
		end
		if (ra_action == ACT_LOCAL && !LOCAL_FUNC_MASK[ra_egress]) begin
			ra_action = ACT_DROP;
		end
		if ((ra_action == ACT_FORWARD || ra_action == ACT_REFLECT || ra_action == ACT_LOCAL)
				&& inactive[ra_egress]) begin
			ra_action = ACT_REJECT;
		end
	end

	// Register file, flags, wake requests and the ordering record.
	always_comb begin
		fatal_next    = 1'b0;
		nonfatal_next = 1'b0;
		rdata_next    = '0;
		rord_next     = 1'b0;
		flood_next    = flood_reg;
		wake_next     = wake_reg;
		epoch_next    = epoch_reg;
		for (int p = 0; p < NUM_PORTS; p++) begin
			bus_next[p]  = bus_reg[p];
			ctrl_next[p] = ctrl_reg[p];
			stat_next[p] = stat_reg[p];
			vw_next[p]   = vw_reg[p];
			lseq_next[p] = lseq_reg[p];
			leg_next[p]  = leg_reg[p];
		end
		if (reg_wr_in && rsel_ok) begin
			if (ridx == REG_BUS && !vt_bound[rport]) begin
				bus_next[rport] = reg_wdata_in;
			end else if (ridx == REG_CTRL) begin
				ctrl_next[rport] = reg_wdata_in;
				ctrl_next[rport][CTRL_PMASK_LSB + rport] = 1'b1;
			end else if (ridx == REG_STAT) begin
				stat_next[rport] = stat_reg[rport] & ~reg_wdata_in[STICKY_W-1:0];
				if (reg_wdata_in[STAT_SSE]) begin
					flood_next[rport] = 1'b0;
				end
			end
		end
		if (reg_rd_in && rsel_ok) begin
			case (ridx)
				REG_BUS: rdata_next = vt_bound[rport] ? '0 : bus_reg[rport];
				REG_CTRL: rdata_next = ctrl_reg[rport];
				REG_STAT: begin
					rdata_next[STICKY_W-1:0] = stat_reg[rport];
					rdata_next[STAT_HOTSWAP] = !hp_n_reg[rport];
					rdata_next[STAT_STOPPED] = stopped[rport];
					rdata_next[STAT_ACTIVE]  = !inactive[rport];
				end
				REG_LINK1: begin
					for (int p = NUM_PORTS - 1; p >= 0; p--) begin
						if (vt_bound[p] && def_port[p] == rport) begin
							rdata_next[STAT_HOTSWAP] = !hp_n_reg[p];
							rdata_next[STAT_STOPPED] = stopped[p];
							rdata_next[STAT_ACTIVE]  = !inactive[p];
						end
					end
				end
				default: rdata_next = '0;
			endcase
		end
		if (ra_valid) begin
			if (ra_chain_err) begin
				stat_next[ing][STAT_CHAIN_END] = 1'b1;
			end
			if (ra_abort) begin
				stat_next[ing][STAT_RMA] = 1'b1;
				if (ctrl_reg[ing][CTRL_MAM_BIT]) begin
					stat_next[ing][STAT_VBUS_ABORT] = 1'b1;
					if (ctrl_reg[ing][CTRL_FLOOD_BIT] && ctrl_reg[ing][CTRL_SERR_BIT]) begin
						stat_next[ing][STAT_SSE] = 1'b1;
						flood_next[ing]          = 1'b1;
					end else if (ctrl_reg[ing][CTRL_FATAL_BIT]) begin
						fatal_next = 1'b1;
					end else if (ctrl_reg[ing][CTRL_NONFATAL_BIT]) begin
						nonfatal_next = 1'b1;
					end
				end
			end
			if (req_kind_in == KIND_SYSMGMT && req_upstream_in) begin
				vw_next[ing][req_vw_line_in] = req_vw_assert_in;
			end
			if (ra_action == ACT_FORWARD || ra_action == ACT_REFLECT) begin
				rord_next = (req_seq_in != '0) && (lseq_reg[ing] == req_seq_in)
					&& (leg_reg[ing] == ra_egress);
				lseq_next[ing] = req_seq_in;
				leg_next[ing]  = ra_egress;
				if (stopped[ra_egress]) begin
					wake_next[ra_egress] = 1'b1;
				end
			end
		end
		if ((fatal_next || nonfatal_next) && stopped[PRIMARY_PORT]) begin
			wake_next[PRIMARY_PORT] = 1'b1;
		end
		for (int p = 0; p < NUM_PORTS; p++) begin
			if (!stopped[p]) begin
				wake_next[p] = 1'b0;
			end
			if (hp_act[p]) begin
				flood_next[p] = 1'b0;
			end
			// Each return to activity opens a new epoch so late responses are recognised.
			if (inact_prev_reg[p] && !inactive[p]) begin
				epoch_next[p] = !epoch_reg[p];
			end
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				bus_reg[p]  <= BUS_RST;
				ctrl_reg[p] <= CTRL_RST;
				stat_reg[p] <= STAT_RST;
				vw_reg[p]   <= '0;
				lseq_reg[p] <= '0;
				leg_reg[p]  <= '0;
			end
			flood_reg      <= '0;
			epoch_reg      <= '0;
			wake_reg       <= '0;
			hp_prev_reg    <= '0;
			inact_prev_reg <= '0;
			reg_rdata_out  <= '0;
			fatal_irq_out  <= 1'b0;
			nonfatal_irq_out <= 1'b0;
		end else begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				bus_reg[p]  <= bus_next[p];
				ctrl_reg[p] <= ctrl_next[p];
				stat_reg[p] <= stat_next[p];
				vw_reg[p]   <= vw_next[p];
				lseq_reg[p] <= lseq_next[p];
				leg_reg[p]  <= leg_next[p];
			end
			flood_reg      <= flood_next;
			epoch_reg      <= epoch_next;
			wake_reg       <= wake_next;
			hp_prev_reg    <= hp_act;
			inact_prev_reg <= inactive;
			reg_rdata_out  <= rdata_next;
			fatal_irq_out  <= fatal_next;
			nonfatal_irq_out <= nonfatal_next;
		end
	end

	// One request per cycle in arrival order keeps merged streams consistent.
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			rv_reg     <= 1'b0;
			ract_reg   <= ACT_NONE;
			reg_eg_reg <= '0;
			rt0_reg    <= 1'b0;
			rord_reg   <= 1'b0;
			rep_reg    <= 1'b0;
			resp_forward_out <= 1'b0;
			resp_discard_out <= 1'b0;
		end else begin
			rv_reg     <= ra_valid;
			ract_reg   <= ra_valid ? ra_action : ACT_NONE;
			reg_eg_reg <= ra_egress;
			rt0_reg    <= ra_valid && ra_type0;
			rord_reg   <= ra_valid && rord_next;
			rep_reg    <= epoch_reg[ra_egress];
			resp_forward_out <= resp_valid_in && !inactive[resp_dest_in]
				&& resp_epoch_in == epoch_reg[resp_dest_in];
			resp_discard_out <= resp_valid_in && (inactive[resp_dest_in]
				|| resp_epoch_in != epoch_reg[resp_dest_in]);
		end
	end

	assign route_valid_out   = rv_reg;
	assign route_action_out  = ract_reg;
	assign route_egress_out  = reg_eg_reg;
	assign route_type0_out   = rt0_reg;
	assign route_ordered_out = rord_reg;
	assign route_epoch_out   = rep_reg;

	always_comb begin
		legacy_wire_interrupt_out = '0;
		for (int p = 0; p < NUM_PORTS; p++) begin
			if (PW'(p) != PRIMARY_PORT && pmask[PRIMARY_PORT][p]) begin
				legacy_wire_interrupt_out = legacy_wire_interrupt_out | vw_reg[p];
			end
		end
		for (int p = 0; p < NUM_PORTS; p++) begin
			link_wake_request_n_out[p] = !wake_reg[p];
			port_cold_reset_out[p]     = hp_prev_reg[p];
			port_tx_enable_out[p]      = !hp_prev_reg[p];
			term_nonposted_out[p]      = hp_act[p] && !hp_prev_reg[p];
			port_link_init_out[p]      = !hp_act[p] && hp_prev_reg[p];
			sync_flood_out[p]          = flood_reg[p];
		end
	end

endmodule

// *** dv/smr_switch_router_assertions.sv ***
`timescale 1ns/1ps
module smr_switch_router_assertions
	import smr_pkg::*;
(
	input wire logic        clk_in,
	input wire logic        sys_rst_in,
	input wire logic        reg_rd_in,
	input wire logic [31:0] reg_rdata_out,
	input wire logic        req_valid_in,
	input wire logic        req_upstream_in,
	input wire smr_kind_t   req_kind_in,
	input wire logic        route_valid_out,
	input wire smr_action_t route_action_out,
	input wire logic [1:0]  route_egress_out,
	input wire logic        resp_valid_in,
	input wire logic        resp_forward_out,
	input wire logic        resp_discard_out,
	input wire logic [3:0]  hotplug_n_in,
	input wire logic [3:0]  port_cold_reset_out,
	input wire logic [3:0]  port_tx_enable_out,
	input wire logic [3:0]  term_nonposted_out,
	input wire logic [3:0]  port_link_init_out,
	input wire logic        fatal_irq_out,
	input wire logic        nonfatal_irq_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	chk_route_pulse: assert property (req_valid_in |=> route_valid_out) else $error("route answer missing");
	chk_route_idle: assert property (!route_valid_out |-> route_action_out == ACT_NONE) else $error("idle action");
	chk_resp_once: assert property (resp_valid_in |=> resp_forward_out != resp_discard_out) else $error("resp");
	chk_tx_tristate: assert property (port_tx_enable_out == ~port_cold_reset_out) else $error("tx enable");
	chk_irq_single: assert property (!(fatal_irq_out && nonfatal_irq_out)) else $error("two irqs");
	chk_rdata_slot: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0) else $error("rdata outside slot");
	chk_up_intr: assert property (req_valid_in && req_upstream_in && req_kind_in == KIND_INTR |=>
		route_egress_out == PRIMARY_PORT && route_action_out inside {ACT_FORWARD, ACT_REJECT}) else $error("intr");
	chk_up_mgmt: assert property (req_valid_in && req_upstream_in && req_kind_in == KIND_SYSMGMT |=>
		route_egress_out == PRIMARY_PORT) else $error("mgmt egress");
	chk_interrupt_acknowledge_down: assert property (req_valid_in && !req_upstream_in && req_kind_in == KIND_INTERRUPT_ACKNOWLEDGE |=>
		route_action_out inside {ACT_FORWARD, ACT_REJECT}) else $error("interrupt_acknowledge");
	chk_hp_reset: assert property ($fell(hotplug_n_in[1]) |-> ##[2:3] port_cold_reset_out[1]) else $error("hp");
	chk_hp_term: assert property ($fell(hotplug_n_in[1]) |-> ##[2:3] term_nonposted_out[1]) else $error("hp term");
	chk_hp_init: assert property ($rose(hotplug_n_in[1]) |-> ##[2:3] port_link_init_out[1]) else $error("hp init");
endmodule
bind smr_switch_router smr_switch_router_assertions u_chk (.clk_in, .sys_rst_in, .reg_rd_in, .reg_rdata_out,
	.req_valid_in, .req_upstream_in, .req_kind_in, .route_valid_out, .route_action_out, .route_egress_out,
	.resp_valid_in, .resp_forward_out, .resp_discard_out, .hotplug_n_in, .port_cold_reset_out,
	.port_tx_enable_out, .term_nonposted_out, .port_link_init_out, .fatal_irq_out, .nonfatal_irq_out);

// *** dv/smr_link_partner.sv ***
`timescale 1ns/1ps
module smr_link_partner (
	input  wire logic       clk_in,
	input  wire logic [3:0] wake_n_in,
	input  wire logic [3:0] stop_req_in,
	input  wire logic [3:0] hp_req_in,
	output logic      [3:0] stop_n_out,
	output logic      [3:0] hotplug_n_out
);
	initial begin
		stop_n_out = 4'hf;
		hotplug_n_out = 4'hf;
	end
	// A stopped link reconnects once the switch asks for it.
	always @(posedge clk_in) begin
		stop_n_out <= (stop_n_out | ~wake_n_in) & ~stop_req_in;
		hotplug_n_out <= ~hp_req_in;
	end
endmodule

// *** dv/tb_switch_message_routing.sv ***
`timescale 1ns/1ps
`define CK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; $display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module tb_switch_message_routing;
	import smr_pkg::*;
	logic        clk_in = 0, sys_rst_in = 1, reg_wr_in = 0, reg_rd_in = 0, req_valid_in = 0, req_upstream_in = 0;
	logic        resp_valid_in = 0, resp_epoch_in = 0, route_valid_out, route_type0_out, route_ordered_out;
	logic        route_epoch_out, resp_forward_out, resp_discard_out, fatal_irq_out, nonfatal_irq_out, ep1, ep2;
	logic [7:0]  reg_addr_in = 0, req_bus_in = 0;
	logic [31:0] reg_wdata_in = 0, reg_rdata_out;
	logic [4:0]  req_dev_in = 0;
	logic [3:0]  req_seq_in = 0, sq = 0, stop_req = 0, hp_req = 0, stop_n, hp_n, wake_n, cold, txen, flood, vw;
	logic        req_vw_assert_in = 1, va = 1;
	logic [1:0]  req_ingress_in = 0, resp_dest_in = 0, route_egress_out;
	smr_kind_t   req_kind_in = KIND_DEVMSG0;
	smr_action_t route_action_out;
	int          failures = 0, checks_done = 0, cyc = 0;
	always #5 clk_in = ~clk_in;
	smr_link_partner u_part (.clk_in(clk_in), .wake_n_in(wake_n), .stop_req_in(stop_req), .hp_req_in(hp_req),
		.stop_n_out(stop_n), .hotplug_n_out(hp_n));
	smr_switch_router dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
		.req_valid_in(req_valid_in), .req_ingress_in(req_ingress_in), .req_upstream_in(req_upstream_in),
		.req_kind_in(req_kind_in), .req_bus_in(req_bus_in), .req_dev_in(req_dev_in), .req_seq_in(req_seq_in),
		.req_vw_line_in(2'h1), .req_vw_assert_in(req_vw_assert_in), .route_valid_out(route_valid_out),
		.route_action_out(route_action_out), .route_egress_out(route_egress_out), .route_type0_out(route_type0_out),
		.route_ordered_out(route_ordered_out), .route_epoch_out(route_epoch_out), .resp_valid_in(resp_valid_in),
		.resp_dest_in(resp_dest_in), .resp_epoch_in(resp_epoch_in), .resp_forward_out(resp_forward_out),
		.resp_discard_out(resp_discard_out), .link_stop_n_in(stop_n), .hotplug_n_in(hp_n),
		.link_wake_request_n_out(wake_n), .port_cold_reset_out(cold), .port_tx_enable_out(txen),
		.port_link_init_out(), .term_nonposted_out(), .sync_flood_out(flood), .fatal_irq_out(fatal_irq_out),
		.nonfatal_irq_out(nonfatal_irq_out), .legacy_wire_interrupt_out(vw));
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge clk_in);
		reg_wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge clk_in);
		reg_rd_in <= 1'b0;
		#1 `CK(reg_rdata_out, e)
	endtask
	task automatic rt(input logic [1:0] ig, input logic up, input smr_kind_t k, input logic [7:0] b,
		input logic [4:0] d, input smr_action_t ea, input logic [1:0] ee, input logic et);
		@(posedge clk_in);
		req_ingress_in <= ig;
		req_upstream_in <= up;
		req_kind_in <= k;
		req_bus_in <= b;
		req_dev_in <= d;
		req_seq_in <= sq;
		req_vw_assert_in <= va;
		req_valid_in <= 1'b1;
		@(posedge clk_in);
		req_valid_in <= 1'b0;
		#1 `CK(route_valid_out, 1'b1)
		`CK(route_action_out, ea)
		`CK(route_egress_out, ee)
		`CK(route_type0_out, et)
	endtask
	task automatic rsp(input logic [1:0] p, input logic ep, input logic f);
		@(posedge clk_in);
		resp_dest_in <= p;
		resp_epoch_in <= ep;
		resp_valid_in <= 1'b1;
		@(posedge clk_in);
		resp_valid_in <= 1'b0;
		#1 `CK(resp_forward_out, f)
		`CK(resp_discard_out, !f)
	endtask
	task automatic ab(input logic [31:0] c, input logic fa, input logic nf, input logic fl);
		wr(8'h01, c);
		rt(2'h0, 1'b0, KIND_DEVMSG1, 8'h01, 5'h07, ACT_DROP, 2'h0, 1'b0);
		`CK(fatal_irq_out, fa)
		`CK(nonfatal_irq_out, nf)
		`CK(flood, {3'h0, fl})
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 3000) begin
			failures++;
			results();
		end
	end
	initial begin
		repeat (5) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		rd(8'h11, CTRL_RST);
		rd(8'h10, BUS_RST);
		rd(8'h02, 32'h40);
		rd(8'h14, 32'h0);
		wr(8'h00, 32'h0007_0100);
		wr(8'h10, 32'h0003_0201);
		wr(8'h20, 32'h0005_0401);
		wr(8'h30, 32'h0007_0601);
		wr(8'h01, 32'hf000_0002);
		rt(2'h0, 1'b0, KIND_DEVMSG1, 8'h04, 5'h0, ACT_FORWARD, 2'h2, 1'b1);
		ep2 = route_epoch_out;
		rt(2'h0, 1'b0, KIND_DEVMSG1, 8'h03, 5'h0, ACT_FORWARD, 2'h1, 1'b0);
		ep1 = route_epoch_out;
		rt(2'h0, 1'b0, KIND_DEVMSG1, 8'h08, 5'h0, ACT_DROP, 2'h0, 1'b0);
		rt(2'h0, 1'b0, KIND_DEVMSG1, 8'h01, 5'h2, ACT_LOCAL, 2'h2, 1'b0);
		rd(8'h02, 32'h42);
		rt(2'h0, 1'b0, KIND_DEVMSG0, 8'h00, 5'h0, ACT_LOCAL, 2'h0, 1'b0);
		rt(2'h0, 1'b0, KIND_DEVMSG0, 8'h00, 5'h3, ACT_DROP, 2'h0, 1'b0);
		rt(2'h1, 1'b1, KIND_DEVMSG0, 8'h00, 5'h0, ACT_LOCAL, 2'h1, 1'b0);
		rt(2'h1, 1'b1, KIND_DEVMSG1, 8'h02, 5'h0, ACT_REFLECT, 2'h1, 1'b1);
		rt(2'h1, 1'b1, KIND_DEVMSG1, 8'h03, 5'h0, ACT_REFLECT, 2'h1, 1'b0);
		rt(2'h1, 1'b1, KIND_DEVMSG1, 8'h01, 5'h2, ACT_LOCAL, 2'h2, 1'b0);
		rt(2'h1, 1'b1, KIND_DEVMSG1, 8'h01, 5'h9, ACT_DROP, 2'h1, 1'b0);
		rt(2'h1, 1'b1, KIND_DEVMSG1, 8'h09, 5'h0, ACT_FORWARD, 2'h0, 1'b0);
		rt(2'h1, 1'b1, KIND_DEVMSG1, 8'h06, 5'h0, ACT_FORWARD, 2'h3, 1'b1);
		rt(2'h1, 1'b1, KIND_DEVMSG1, 8'h07, 5'h0, ACT_FORWARD, 2'h3, 1'b0);
		wr(8'h11, 32'hf020_0000);
		rt(2'h1, 1'b1, KIND_DEVMSG0, 8'h00, 5'h0, ACT_DROP, 2'h1, 1'b0);
		sq = 4'h5;
		rt(2'h2, 1'b1, KIND_INTR, 8'h00, 5'h0, ACT_FORWARD, 2'h0, 1'b0);
		rt(2'h2, 1'b1, KIND_INTR, 8'h00, 5'h0, ACT_FORWARD, 2'h0, 1'b0);
		`CK(route_ordered_out, 1'b1)
		rt(2'h3, 1'b1, KIND_SYSMGMT, 8'h00, 5'h0, ACT_FORWARD, 2'h0, 1'b0);
		`CK(route_ordered_out, 1'b0)
		`CK(vw, 4'h2)
		sq = 4'h0;
		rt(2'h0, 1'b0, KIND_INTERRUPT_ACKNOWLEDGE, 8'h00, 5'h0, ACT_FORWARD, 2'h2, 1'b0);
		va = 1'b0;
		rt(2'h3, 1'b1, KIND_SYSMGMT, 8'h00, 5'h0, ACT_FORWARD, 2'h0, 1'b0);
		`CK(vw, 4'h0)
		va = 1'b1;
		wr(8'h30, 32'h0007_0501);
		rt(2'h0, 1'b0, KIND_DEVMSG1, 8'h05, 5'h0, ACT_DROP, 2'h0, 1'b0);
		rt(2'h1, 1'b1, KIND_DEVMSG1, 8'h05, 5'h0, ACT_DROP, 2'h1, 1'b0);
		$display("test routing done");
		ab(32'hf440_0002, 1'b0, 1'b1, 1'b0);
		ab(32'hf240_0002, 1'b1, 1'b0, 1'b0);
		ab(32'hf1c0_0002, 1'b0, 1'b0, 1'b1);
		rd(8'h02, 32'h0f);
		rt(2'h1, 1'b1, KIND_DEVMSG1, 8'h09, 5'h0, ACT_REJECT, 2'h0, 1'b0);
		wr(8'h02, 32'hf);
		rd(8'h02, 32'h40);
		$display("test abort done");
		@(posedge clk_in) hp_req <= 4'h2;
		repeat (4) @(posedge clk_in);
		#1 `CK(cold, 4'h2)
		`CK(txen, 4'hd)
		rd(8'h12, 32'h16);
		rt(2'h0, 1'b0, KIND_DEVMSG1, 8'h03, 5'h0, ACT_REJECT, 2'h1, 1'b0);
		rsp(2'h1, ep1, 1'b0);
		@(posedge clk_in) hp_req <= 4'h0;
		repeat (4) @(posedge clk_in);
		rsp(2'h1, ep1, 1'b0);
		rsp(2'h2, ep2, 1'b1);
		$display("test hot plug done");
		@(posedge clk_in) stop_req <= 4'h1;
		@(posedge clk_in) stop_req <= 4'h0;
		repeat (4) @(posedge clk_in);
		ab(32'hf240_0002, 1'b1, 1'b0, 1'b0);
		repeat (5) if (wake_n[0]) @(posedge clk_in);
		`CK(wake_n[0], 1'b0)
		repeat (6) @(posedge clk_in);
		#1 `CK(wake_n, 4'hf)
		$display("test wake done");
		wr(8'h31, 32'hf800_0000);
		rd(8'h30, 32'h0);
		rd(8'h03, 32'h40);
		rt(2'h1, 1'b1, KIND_DEVMSG1, 8'h07, 5'h0, ACT_DROP, 2'h1, 1'b0);
		$display("test tunnel done");
		results();
	end
endmodule
